/* File: bench/logic_rotate_datapath_props.sv */
// Purpose: Port checks for logic_rotate_datapath.
// Assumes: No request before reset has settled.
// Notes: Memory is unseen here, so memory results are left to the bench.
`default_nettype none
module lrd_check
	import logic_rotate_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire op_t op,
	input wire logic busy,
	input wire logic done,
	input wire logic [7:0] accumulator,
	input wire logic zeroFlag,
	input wire logic carryFlag
);
	op_t held;
	wire logic take = start && !busy && op != opNone;
	always_ff @(posedge clk) if (take) held <= op;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	answer_time_a: assert property (take |=> busy ##1 busy ##1 done && !busy)
		else $error("done not after three cycles");
	store_keeps_a: assert property (done && held == opStoreAccLong |->
		$stable({accumulator, zeroFlag, carryFlag})) else $error("store changed state");
	or_bits_a: assert property (done && held == opOrIntoAccLong |->
		(accumulator & $past(accumulator)) == $past(accumulator)) else $error("or lost bits");
	or_zero_a: assert property (done && held == opOrIntoAccLong |-> $stable(carryFlag) &&
		zeroFlag == (accumulator == 8'h00)) else $error("or flags wrong");
	orm_keeps_a: assert property (done && held == opOrIntoMemLong |->
		$stable({accumulator, carryFlag})) else $error("or to memory changed state");
	rot_keeps_a: assert property (done && held == opRotateLeftMemLong |->
		$stable({accumulator, zeroFlag, carryFlag})) else $error("rotate changed state");
	rota_flags_a: assert property (done && held == opRotateLeftToAccLong |->
		$stable({zeroFlag, carryFlag})) else $error("rotate to acc changed flags");
	rotc_zero_a: assert property (done && held == opRotateLeftCarryLong |->
		$stable({accumulator, zeroFlag})) else $error("carry rotate changed zero");
	done_pulse_a: assert property (done |=> !done) else $error("done too long");
endmodule : lrd_check
bind logic_rotate_datapath lrd_check lrd_check_u (.clk(clk), .rst_b(rst_b), .start(start),
	.op(op), .busy(busy), .done(done), .accumulator(accumulator), .zeroFlag(zeroFlag),
	.carryFlag(carryFlag));
`default_nettype wire

/* File: bench/test_logic_rotate_datapath.sv */
// Purpose: Self-checking bench for logic_rotate_datapath.
// Assumes: Memory bytes are preloaded through the hierarchy.
// Notes: Carry starts at 0 from reset.
`default_nettype none
module test_logic_rotate_datapath import logic_rotate_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, start = 0, busy, done, zeroFlag, carryFlag;
	op_t op = opNone;
	logic [7:0] addr = 8'h00, accumulator;
	int fail_count = 0, samples_checked = 0, cycles = 0;
	always #10 clk = ~clk;
	logic_rotate_datapath dut_u (.clk(clk), .rst_b(rst_b), .start(start), .op(op),
		.addr(addr), .busy(busy), .done(done), .accumulator(accumulator),
		.zeroFlag(zeroFlag), .carryFlag(carryFlag));
	task complete_run();
		if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Next request goes out in the done cycle, the tightest spacing allowed
	task run(input op_t o, input logic [7:0] a);
		op = o;
		addr = a;
		start = 1;
		@(posedge clk) #1 start = 0;
		repeat (2) @(posedge clk) #1;
		chk("done", 8'h01, done);
	endtask : run
	task or_scen();
		dut_u.uMem.mem[8'h11] = 8'h00;
		dut_u.uMem.mem[8'h10] = 8'h81;
		dut_u.uMem.mem[8'h21] = 8'h42;
		dut_u.uMem.mem[8'h30] = 8'h80;
		dut_u.uMem.mem[8'h31] = 8'h24;
		run(opOrIntoAccLong, 8'h11);
		chk("zero", 8'h01, zeroFlag);
		run(opOrIntoMemLong, 8'h31);
		chk("mem31", 8'h24, dut_u.uMem.mem[8'h31]);
		chk("zero", 8'h00, zeroFlag);
		run(opOrIntoAccLong, 8'h10);
		chk("acc", 8'h81, accumulator);
		chk("zero", 8'h00, zeroFlag);
		run(opOrIntoMemLong, 8'h21);
		chk("mem21", 8'hc3, dut_u.uMem.mem[8'h21]);
		run(opStoreAccLong, 8'h20);
		chk("mem20", 8'h81, dut_u.uMem.mem[8'h20]);
		chk("acc", 8'h81, accumulator);
	endtask : or_scen
	task rot_scen();
		run(opRotateLeftMemLong, 8'h10);
		chk("mem10", 8'h03, dut_u.uMem.mem[8'h10]);
		run(opRotateLeftToAccLong, 8'h21);
		chk("acc", 8'h87, accumulator);
		chk("mem21", 8'hc3, dut_u.uMem.mem[8'h21]);
		run(opRotateLeftCarryLong, 8'h30);
		chk("mem30", 8'h00, dut_u.uMem.mem[8'h30]);
		chk("carry", 8'h01, carryFlag);
		chk("zero", 8'h00, zeroFlag);
		run(opRotateLeftCarryLong, 8'h10);
		chk("mem10", 8'h07, dut_u.uMem.mem[8'h10]);
		chk("carry", 8'h00, carryFlag);
	endtask : rot_scen
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_b = 1;
		repeat (3) @(posedge clk) #1;
		or_scen();
		rot_scen();
		repeat (3) @(posedge clk) #1;
		complete_run();
	end
endmodule : test_logic_rotate_datapath
`default_nettype wire

/* File: src/data_mem.sv */
// Purpose: Small synchronous data memory with registered read data.
// Assumes: One shared port; a write cycle also reads out the old byte at that address.
// Notes: Read data appear the cycle after the read request.
`include "logic_rotate_regs.svh"
`default_nettype none
module data_mem #(
	parameter int DATA_W = `LRD_DATA_W,
	parameter int ADDR_W = `LRD_ADDR_W
) (
	input wire logic clk,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wrData,
	output logic [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[addr] <= wrData;
		end
		rdData <= mem[addr];
	end
endmodule : data_mem
`default_nettype wire

/* File: src/logic_rotate_datapath.sv */
// Purpose: Executes store, OR and left-rotate instructions on a data memory byte.
// Assumes: One instruction is accepted when start is high and busy is low.
// Notes: Each instruction takes three cycles: read, execute, then done pulse.
`include "logic_rotate_regs.svh"
`default_nettype none
module logic_rotate_datapath
	import logic_rotate_pkg::*;
#(
	parameter int DATA_W = `LRD_DATA_W,
	parameter int ADDR_W = `LRD_ADDR_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire op_t op,
	input wire logic [ADDR_W-1:0] addr,
	output logic busy,
	output logic done,
	output logic [DATA_W-1:0] accumulator,
	output logic zeroFlag,
	output logic carryFlag
);
	logic rstSync1_b;
	logic rstSync_b;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstSync1_b <= 1'b1;
			rstSync_b <= rstSync1_b;
		end
	end

	// Rotating left by one; the caller chooses what enters bit 0
	function automatic logic [DATA_W-1:0] rotl(
		input logic [DATA_W-1:0] v,
		input logic lsb
	);
		rotl = {v[DATA_W-2:0], lsb};
	endfunction : rotl

	// Zero test shared by both OR forms
	function automatic logic isZero(input logic [DATA_W-1:0] v);
		isZero = (v == '0);
	endfunction : isZero

	// Decodes: which instructions write the byte, load the accumulator or touch zero
	function automatic logic writesMem(input op_t o);
		unique case (o)
			opStoreAccLong,
			opOrIntoMemLong,
			opRotateLeftMemLong,
			opRotateLeftCarryLong: begin
				writesMem = 1'b1;
			end
			default: begin
				// The accumulator-only forms leave the byte as it was
				writesMem = 1'b0;
			end
		endcase
	endfunction : writesMem

	function automatic logic loadsAcc(input op_t o);
		unique case (o)
			opOrIntoAccLong,
			opRotateLeftToAccLong: begin
				loadsAcc = 1'b1;
			end
			default: begin
				loadsAcc = 1'b0;
			end
		endcase
	endfunction : loadsAcc

	function automatic logic touchesZero(input op_t o);
		unique case (o)
			opOrIntoAccLong,
			opOrIntoMemLong: begin
				touchesZero = 1'b1;
			end
			default: begin
				// Store and all rotates leave the zero flag alone
				touchesZero = 1'b0;
			end
		endcase
	endfunction : touchesZero

	function automatic logic [DATA_W-1:0] execResult(
		input op_t o,
		input logic [DATA_W-1:0] acc,
		input logic [DATA_W-1:0] mem,
		input logic cin
	);
		unique case (o)
			opOrIntoAccLong,
			opOrIntoMemLong: begin
				execResult = acc | mem;
			end
			opRotateLeftMemLong,
			opRotateLeftToAccLong: begin
				execResult = rotl(mem, mem[`LRD_MSB]);
			end
			opRotateLeftCarryLong: begin
				execResult = rotl(mem, cin);
			end
			default: begin
				execResult = acc;
			end
		endcase
	endfunction : execResult

	state_t state;
	state_t next_state;
	op_t curOp;
	op_t next_curOp;
	logic [ADDR_W-1:0] curAddr;
	logic [ADDR_W-1:0] next_curAddr;
	logic next_busy;
	logic next_done;
	logic [DATA_W-1:0] next_accumulator;
	logic next_zeroFlag;
	logic next_carryFlag;
	logic execStep;
	logic memWrEn;
	logic [DATA_W-1:0] memWrData;
	logic [DATA_W-1:0] memRdData;
	logic [DATA_W-1:0] result;

	data_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) uMem (
		.clk(clk),
		.wrEn(memWrEn),
		.addr(curAddr),
		.wrData(memWrData),
		.rdData(memRdData)
	);

	// Control: one instruction walks idle, read, execute and back to idle
	always_comb begin
		next_state = state;
		next_curOp = curOp;
		next_curAddr = curAddr;
		next_busy = busy;
		next_done = 1'b0;
		unique case (state)
			stIdle: begin
				// A request while busy is dropped without trace; callers pace on done
				if (start && op != opNone) begin
					next_curOp = op;
					next_curAddr = addr;
					next_busy = 1'b1;
					next_state = stRead;
				end
			end
			stRead: begin
				// Memory read data are registered, so wait one cycle
				next_state = stExec;
			end
			stExec: begin
				next_state = stIdle;
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			default: begin
				next_state = stIdle;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			state <= stIdle;
			curOp <= opNone;
			curAddr <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			curOp <= next_curOp;
			curAddr <= next_curAddr;
			busy <= next_busy;
			done <= next_done;
		end
	end

	// Memory port: the write lands at the same edge as done rises
	assign execStep = (state == stExec);
	assign result = execResult(curOp, accumulator, memRdData, carryFlag);
	assign memWrEn = execStep && writesMem(curOp);
	assign memWrData = result;

	// Accumulator and flags: only the execute step may change them
	always_comb begin
		next_accumulator = accumulator;
		next_zeroFlag = zeroFlag;
		next_carryFlag = carryFlag;
		if (execStep) begin
			if (loadsAcc(curOp)) begin
				next_accumulator = result;
			end
			if (touchesZero(curOp)) begin
				next_zeroFlag = isZero(result);
			end
			if (curOp == opRotateLeftCarryLong) begin
				// Carry takes the old top bit, not the top bit of the result
				next_carryFlag = memRdData[`LRD_MSB];
			end
		end
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			accumulator <= `LRD_ACC_RST;
			zeroFlag <= `LRD_FLAG_RST;
			carryFlag <= `LRD_FLAG_RST;
		end else begin
			accumulator <= next_accumulator;
			zeroFlag <= next_zeroFlag;
			carryFlag <= next_carryFlag;
		end
	end
endmodule : logic_rotate_datapath
`default_nettype wire

/* File: src/logic_rotate_pkg.sv */
// Purpose: Types for the logic and rotate datapath.
// Assumes: Nothing beyond the constants header.
// Notes: Opcode codes are left to the tool.
`default_nettype none
package logic_rotate_pkg;
	typedef enum logic [2:0] {
		opNone,
		opStoreAccLong,
		opOrIntoAccLong,
		opOrIntoMemLong,
		opRotateLeftMemLong,
		opRotateLeftToAccLong,
		opRotateLeftCarryLong
	} op_t;
	typedef enum logic [1:0] {stIdle, stRead, stExec} state_t;
endpackage : logic_rotate_pkg
`default_nettype wire

/* File: src/logic_rotate_regs.svh */
// Purpose: Constants for the long-addressed logic and rotate datapath.
// Assumes: 8-bit data memory bytes, one carry and one zero flag.
`ifndef LOGIC_ROTATE_REGS_SVH
`define LOGIC_ROTATE_REGS_SVH
`define LRD_DATA_W 8
`define LRD_ADDR_W 8
`define LRD_MSB 7
`define LRD_ACC_RST 8'h00
`define LRD_FLAG_RST 1'b0
`endif
